//--- pzt_pkg.sv
// Shared constants and types for the pipelined zero-turnaround memory port
package pzt_pkg;

  // ==========================================================
  // Widths of the x36 organisation
  localparam int PZT_AW = 17;
  localparam int PZT_DW = 36;
  localparam int PZT_LANES = 4;
  localparam int PZT_LANE_W = 9;
  localparam int PZT_DEPTH = 1 << PZT_AW;

  // ==========================================================
  // Burst counter and pin reset values
  localparam logic [1:0] PZT_BEAT_FIRST = 2'h0;
  localparam logic [1:0] PZT_BEAT_STEP = 2'h1;
  localparam logic PZT_GATE_RST = 1'h0;
  localparam logic PZT_SEL_A_OFF = 1'h1;
  localparam logic PZT_SEL_B_OFF = 1'h0;
  localparam logic PZT_SEL_C_OFF = 1'h1;
  localparam logic [PZT_LANES-1:0] PZT_BW_NONE = 4'hf;
  localparam logic [PZT_DW-1:0] PZT_WORD_ZERO = 36'h0;

  // ==========================================================
  // Burst direction held by the device between loads
  typedef enum logic [1:0] {
    PZT_IDLE,
    PZT_RD_BURST,
    PZT_WR_BURST
  } pzt_burst_t;

endpackage

//--- pzt_bus_if.sv
// Bus between the memory device end and the bus master end
`timescale 1ns/1ns
interface pzt_bus_if import pzt_pkg::*; ();

  // ==========================================================
  // Address and control, driven by the master
  logic [PZT_AW-1:0] addr;
  logic read_not_write;
  logic advance_or_load_select;
  logic chip_select_low_a;
  logic chip_select_pair_b;
  logic chip_select_low_c;
  logic clock_gate_bar;
  logic [PZT_LANES-1:0] byte_write_strobe;
  logic burst_order_select;
  logic output_drive_bar;

  // ==========================================================
  // Shared data bus as separate drives, resolved below
  logic [PZT_DW-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [PZT_DW-1:0] mst_dq_o;
  logic mst_dq_oe;
  logic [PZT_DW-1:0] dq;

  // Undriven bus reads as zero; device wins a clash
  assign dq = dev_dq_oe ? dev_dq_o : (mst_dq_oe ? mst_dq_o : PZT_WORD_ZERO);

  modport dev (
    input addr, read_not_write, advance_or_load_select,
    input chip_select_low_a, chip_select_pair_b, chip_select_low_c,
    input clock_gate_bar, byte_write_strobe, burst_order_select,
    input output_drive_bar, dq,
    output dev_dq_o, dev_dq_oe
  );

  modport mst (
    output addr, read_not_write, advance_or_load_select,
    output chip_select_low_a, chip_select_pair_b, chip_select_low_c,
    output clock_gate_bar, byte_write_strobe, burst_order_select,
    output output_drive_bar, mst_dq_o, mst_dq_oe,
    input dq
  );

endinterface // pzt_bus_if

//--- pzt_sram_mst.sv
// Bus master end: turns a beat stream into pipelined memory cycles
`timescale 1ns/1ns
module pzt_sram_mst import pzt_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  pzt_bus_if.mst BUS,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_LOAD,
  input wire logic CMD_WRITE,
  input wire logic [PZT_AW-1:0] CMD_ADDR,
  input wire logic [PZT_DW-1:0] CMD_WDATA,
  input wire logic [PZT_LANES-1:0] CMD_BYTE_N,
  input wire logic SUSPEND,
  input wire logic BURST_ORDER,
  output logic RD_VALID,
  output logic [PZT_DW-1:0] RD_DATA
);

  // ==========================================================
  // Edge qualification
  logic gate_r;
  logic bus_en;
  logic take;
  logic beat_wr;
  logic dir_r;

  // The coming edge is enabled when the gate now on the wire is low
  assign bus_en = ~gate_r;
  assign take = CMD_VALID & bus_en;
  assign CMD_READY = bus_en;
  // Advance beats keep the direction of their load
  assign beat_wr = CMD_LOAD ? CMD_WRITE : dir_r;

  // ==========================================================
  // Presented address and control
  logic [PZT_AW-1:0] addr_r;
  logic rnw_r;
  logic adv_r;
  logic sel_a_r;
  logic sel_b_r;
  logic sel_c_r;
  logic [PZT_LANES-1:0] bw_r;
  logic order_r;

  // Gate is registered so its edge is known one cycle ahead
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      gate_r <= PZT_GATE_RST;
    else
      gate_r <= SUSPEND;
  end

  // Control changes only on enabled edges, held across suspends
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      addr_r <= '0;
      rnw_r <= 1'b1;
      adv_r <= 1'b0;
      sel_a_r <= PZT_SEL_A_OFF;
      sel_b_r <= PZT_SEL_B_OFF;
      sel_c_r <= PZT_SEL_C_OFF;
      bw_r <= PZT_BW_NONE;
      dir_r <= 1'b0;
      order_r <= 1'b0;
    end
    else if (bus_en)
    begin
      order_r <= BURST_ORDER;
      addr_r <= CMD_ADDR;
      // Passed through on advances too, where the device ignores it
      rnw_r <= ~CMD_WRITE;
      adv_r <= take & ~CMD_LOAD;
      sel_a_r <= ~take;
      sel_b_r <= take;
      sel_c_r <= ~take;
      bw_r <= take ? CMD_BYTE_N : PZT_BW_NONE;
      if (take & CMD_LOAD)
        dir_r <= CMD_WRITE;
    end
  end

  assign BUS.addr = addr_r;
  assign BUS.read_not_write = rnw_r;
  assign BUS.advance_or_load_select = adv_r;
  assign BUS.chip_select_low_a = sel_a_r;
  assign BUS.chip_select_pair_b = sel_b_r;
  assign BUS.chip_select_low_c = sel_c_r;
  assign BUS.clock_gate_bar = gate_r;
  assign BUS.byte_write_strobe = bw_r;
  assign BUS.burst_order_select = order_r;
  assign BUS.output_drive_bar = 1'b0;

  // ==========================================================
  // Data pipeline: stage a is presented, c drives or samples
  logic a_vld_r, b_vld_r, c_vld_r;
  logic a_wr_r, b_wr_r, c_wr_r;
  logic [PZT_DW-1:0] a_d_r, b_d_r, c_d_r;

  // Two enabled edges after the address, data meets the bus
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      {a_vld_r, b_vld_r, c_vld_r} <= 3'h0;
      {a_wr_r, b_wr_r, c_wr_r} <= 3'h0;
      a_d_r <= '0;
      b_d_r <= '0;
      c_d_r <= '0;
    end
    else if (bus_en)
    begin
      a_vld_r <= take;
      a_wr_r <= beat_wr;
      a_d_r <= CMD_WDATA;
      b_vld_r <= a_vld_r;
      b_wr_r <= a_wr_r;
      b_d_r <= a_d_r;
      c_vld_r <= b_vld_r;
      c_wr_r <= b_wr_r;
      c_d_r <= b_d_r;
    end
  end

  // Drive only write beats; back-to-back bursts need no gap
  assign BUS.mst_dq_oe = c_vld_r & c_wr_r;
  assign BUS.mst_dq_o = c_d_r;

  // ==========================================================
  // Read return, sampled on the enabled edge closing the data cycle
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RD_VALID <= 1'b0;
      RD_DATA <= '0;
    end
    else
    begin
      RD_VALID <= bus_en & c_vld_r & ~c_wr_r;
      if (bus_en & c_vld_r & ~c_wr_r)
        RD_DATA <= BUS.dq;
    end
  end

endmodule // pzt_sram_mst

//--- pzt_sram_dev.sv
// Memory device end: pipelined zero-turnaround static memory with bursts
`timescale 1ns/1ns
module pzt_sram_dev import pzt_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  pzt_bus_if.dev BUS,
  output logic BUSY
);

  // ==========================================================
  // Storage
  // Word-wide array; byte lanes are merged before each store
  // Contents are not cleared by reset; a word never written
  // reads back as unknown data
  logic [PZT_DW-1:0] mem [0:PZT_DEPTH-1];

  // ==========================================================
  // Input decode
  logic en;
  logic sel;
  logic load_sel;
  logic load_desel;
  logic advance;
  logic issue;

  // A gated edge moves nothing at all
  assign en = ~BUS.clock_gate_bar;
  // Composite select; any false select means deselected
  assign sel = ~BUS.chip_select_low_a & BUS.chip_select_pair_b
    & ~BUS.chip_select_low_c;
  assign load_sel = en & ~BUS.advance_or_load_select & sel;
  // A deselect load closes any open burst; pending beats still finish
  assign load_desel = en & ~BUS.advance_or_load_select & ~sel;

  // ==========================================================
  // Burst state and counter
  pzt_burst_t state_r;
  logic [PZT_AW-1:0] base_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] low_lin;
  logic [1:0] low_int;
  logic [1:0] beat_low;
  logic [PZT_AW-1:0] beat_addr;
  logic beat_wr;
  logic load_wr;

  // Advancing outside a burst does nothing
  assign advance = en & BUS.advance_or_load_select
    & (state_r != PZT_IDLE);
  assign issue = load_sel | advance;
  assign cnt_nxt = cnt_r + PZT_BEAT_STEP;
  // Both orders wrap after four beats and keep counting
  assign low_lin = base_r[1:0] + cnt_nxt;
  assign low_int = base_r[1:0] ^ cnt_nxt;
  // Order is taken on each advance edge; upper bits never move
  assign beat_low = BUS.burst_order_select ? low_int : low_lin;
  assign beat_addr = {base_r[PZT_AW-1:2], beat_low};
  // Direction comes from the load, never from the advance cycle
  assign beat_wr = (state_r == PZT_WR_BURST);
  // Read/write on the pins is looked at only on a selected load
  assign load_wr = ~BUS.read_not_write;

  // Load takes address and direction; deselect ends the burst
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= PZT_IDLE;
      base_r <= '0;
      cnt_r <= PZT_BEAT_FIRST;
    end
    else if (load_sel)
    begin
      state_r <= load_wr ? PZT_WR_BURST : PZT_RD_BURST;
      base_r <= BUS.addr;
      cnt_r <= PZT_BEAT_FIRST;
    end
    else if (load_desel)
      state_r <= PZT_IDLE;
    // Counter is two bits, so a fourth advance wraps to the start
    else if (advance)
      cnt_r <= cnt_nxt;
  end

  // ==========================================================
  // Address pipeline: stage 1 after the load edge, stage 2 after the next
  logic s1_vld_r, s2_vld_r;
  logic s1_wr_r, s2_wr_r;
  logic [PZT_AW-1:0] s1_addr_r, s2_addr_r;
  logic [PZT_LANES-1:0] s1_bw_r, s2_bw_r;

  // Pipeline registers only move on enabled edges
  // Strobes travel with each beat's address edge, not with its data
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s1_vld_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_addr_r <= '0;
      s1_bw_r <= PZT_BW_NONE;
      s2_vld_r <= 1'b0;
      s2_wr_r <= 1'b0;
      s2_addr_r <= '0;
      s2_bw_r <= PZT_BW_NONE;
    end
    else if (en)
    begin
      s1_vld_r <= issue;
      s1_wr_r <= load_sel ? load_wr : beat_wr;
      s1_addr_r <= load_sel ? BUS.addr : beat_addr;
      s1_bw_r <= BUS.byte_write_strobe;
      s2_vld_r <= s1_vld_r;
      s2_wr_r <= s1_wr_r;
      s2_addr_r <= s1_addr_r;
      s2_bw_r <= s1_bw_r;
    end
  end

  // ==========================================================
  // Write path: lane merge of bus data into the stored word
  logic [PZT_DW-1:0] old_word;
  logic [PZT_DW-1:0] merged;
  logic store;

  assign old_word = mem[s2_addr_r];
  // Write data is taken two enabled edges after its address
  // A gated edge in between stretches the wait but never skips a beat
  assign store = en & s2_vld_r & s2_wr_r;

  // Strobe high keeps the stored lane; all high stores nothing
  for (genvar g = 0; g < PZT_LANES; g++)
  begin : g_lane
    assign merged[g*PZT_LANE_W +: PZT_LANE_W] = s2_bw_r[g]
      ? old_word[g*PZT_LANE_W +: PZT_LANE_W]
      : BUS.dq[g*PZT_LANE_W +: PZT_LANE_W];
  end

  // Array write, no reset on storage contents
  always_ff @(posedge SYS_CLK)
  begin
    if (store)
      mem[s2_addr_r] <= merged;
  end

  // ==========================================================
  // Read path with bypass of the write committed on the same edge
  logic [PZT_DW-1:0] rd_word;
  logic bypass;
  logic [PZT_DW-1:0] dout_r;
  logic rd_vld_r;
  logic rd_issue;

  // Without the bypass a read right behind a write sees stale data
  // The merged word is used so that unwritten lanes keep old data
  assign bypass = store & (s2_addr_r == s1_addr_r);
  assign rd_word = bypass ? merged : mem[s1_addr_r];
  // A read beat sits in stage 1 when its word must be fetched
  assign rd_issue = s1_vld_r & ~s1_wr_r;

  // Read word registered at edge n+1, on the bus in cycle n+2
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dout_r <= '0;
      rd_vld_r <= 1'b0;
    end
    else if (en)
    begin
      rd_vld_r <= rd_issue;
      if (rd_issue)
        dout_r <= rd_word;
    end
  end

  // Output drive enable acts without the clock, as on the pin
  assign BUS.dev_dq_oe = rd_vld_r & ~BUS.output_drive_bar;
  assign BUS.dev_dq_o = dout_r;

  // ==========================================================
  // Status
  // High while a burst is open or a transfer is still in the pipe
  // Idle only after deselects have closed the burst and the pipe drained
  assign BUSY = (state_r != PZT_IDLE) | s1_vld_r | s2_vld_r | rd_vld_r;

endmodule // pzt_sram_dev

//--- pzt_bus_monitor.sv
// Checker of the bus between the master and device ends
`timescale 1ns/1ns
module pzt_bus_monitor import pzt_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic read_not_write,
  input wire logic advance_or_load_select,
  input wire logic chip_select_low_a,
  input wire logic chip_select_pair_b,
  input wire logic chip_select_low_c,
  input wire logic clock_gate_bar,
  input wire logic dev_dq_oe
);
  // ==========
  // Cycle decode; a gated edge counts for nothing
  wire en = !clock_gate_bar;
  wire sel = !chip_select_low_a && chip_select_pair_b && !chip_select_low_c;
  wire adv = en && advance_or_load_select;
  wire ld = en && !advance_or_load_select;
  wire dsl = ld && !sel;
  wire rdl = ld && sel && read_not_write;
  wire wrl = ld && sel && !read_not_write;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // ==========
  // Device pipeline, counted in enabled edges
  a_read_latency:
    assert property (rdl ##1 en |=> dev_dq_oe)
    else $error("read word not driven two enabled edges after load");
  a_deselect_idle:
    assert property (dsl ##1 dsl |=> !dev_dq_oe)
    else $error("device drove the bus after deselects");
  a_gate_holds:
    assert property (!en |=> $stable(dev_dq_oe))
    else $error("gated edge changed the data drive");
  a_burst_streams:
    assert property (rdl ##1 adv [*3] ##1 en |=> dev_dq_oe)
    else $error("burst read beat missing");
  a_reload_gapless:
    assert property (rdl ##1 adv [*3] ##1 rdl ##1 en |-> dev_dq_oe ##1 dev_dq_oe)
    else $error("dead cycle between read bursts");
  a_write_silent:
    assert property (wrl ##1 en |=> !dev_dq_oe)
    else $error("device drove the bus in a write data cycle");
  a_dir_at_load:
    assert property (wrl ##1 adv ##1 en |=> !dev_dq_oe)
    else $error("write burst advance turned into a read");
  a_rise_enabled:
    assert property ($rose(dev_dq_oe) |-> $past(en))
    else $error("data drive started after a gated edge");

  // Main traffic shapes seen on the bus
  c_read_burst: cover property (rdl ##1 adv [*3]);
  c_write_burst: cover property (wrl ##1 adv [*3]);
  c_gated_read: cover property (rdl ##1 !en);
endmodule // pzt_bus_monitor

//--- pipelined_zero_turnaround_sram_port_bench.sv
// Bench joining the master and device ends across the shared bus
`timescale 1ns/1ns
module pipelined_zero_turnaround_sram_port_bench import pzt_pkg::*; ;
  // ==========
  // Stimulus, reference memory and tallies
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic cv = 1'h0, cl = 1'h0, cw = 1'h0, sus = 1'h0, bo = 1'h0;
  logic ord = 1'h0, dir = 1'h0;
  logic [PZT_AW-1:0] ca = 17'h0, base = 17'h0;
  logic [PZT_DW-1:0] cd = 36'h0, rdd;
  logic [PZT_LANES-1:0] cb = 4'hf;
  logic rdy, rdv, busy;
  int k = 0, failures = 0, n_tests = 0;
  bit gap = 1'b0;
  logic [PZT_DW-1:0] mem [int];
  logic [PZT_DW-1:0] expq [$], gotq [$];
  logic [PZT_AW-1:0] ra [4] = '{17'h5, 17'h6, 17'h7, 17'h8};
  logic [PZT_LANES-1:0] rb [4] = '{4'h0, 4'he, 4'h6, 4'hf};
  logic [PZT_DW-1:0] rx [4] = '{36'h9abcdef12, 36'h000000112,
                                36'h9a8000112, 36'h0};

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  pzt_bus_if bus ();
  pzt_sram_mst u_pzt_sram_mst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .BUS(bus), .CMD_VALID(cv),
    .CMD_READY(rdy), .CMD_LOAD(cl), .CMD_WRITE(cw), .CMD_ADDR(ca),
    .CMD_WDATA(cd), .CMD_BYTE_N(cb), .SUSPEND(sus), .BURST_ORDER(bo),
    .RD_VALID(rdv), .RD_DATA(rdd)
  );
  pzt_sram_dev u_pzt_sram_dev (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .BUS(bus), .BUSY(busy)
  );
  pzt_bus_monitor u_pzt_bus_monitor (
    .SYS_CLK(sys_clk), .RST_N(rst_n),
    .read_not_write(bus.read_not_write),
    .advance_or_load_select(bus.advance_or_load_select),
    .chip_select_low_a(bus.chip_select_low_a),
    .chip_select_pair_b(bus.chip_select_pair_b),
    .chip_select_low_c(bus.chip_select_low_c),
    .clock_gate_bar(bus.clock_gate_bar), .dev_dq_oe(bus.dev_dq_oe)
  );

  // Read words arrive in issue order, so a queue is enough
  always @(posedge sys_clk)
    if (rdv === 1'b1)
      gotq.push_back(rdd);

  // ==========
  // Shared tasks
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Offer one beat; the model steps its own burst counter
  task automatic beat(input logic l, input logic w,
                      input logic [PZT_AW-1:0] a, input logic [PZT_DW-1:0] d,
                      input logic [PZT_LANES-1:0] bn, input logic s);
    logic [PZT_AW-1:0] x;
    if (l)
    begin
      base = a;
      dir = w;
      k = 0;
    end
    else
      k++;
    x = base;
    x[1:0] = ord ? base[1:0] ^ k[1:0] : base[1:0] + k[1:0];
    if (dir)
    begin
      for (int i = 0; i < PZT_LANES; i++)
        if (!bn[i])
          mem[x][i*PZT_LANE_W +: PZT_LANE_W] = d[i*PZT_LANE_W +: PZT_LANE_W];
    end
    else
      expq.push_back(mem[x]);
    cv <= 1'h1;
    cl <= l;
    cw <= w;
    ca <= a;
    cd <= d;
    cb <= bn;
    bo <= ord;
    // The edge after a suspended beat is gated; the suspend is held
    // back to the taking edge, else it would gate every edge after
    sus <= gap ? 1'h0 : s;
    #1 chk(rdy === ~gap, "ready");
    @(posedge sys_clk);
    if (gap)
    begin
      sus <= s;
      #1 chk(rdy === 1'b1, "ready after gate");
      @(posedge sys_clk);
    end
    gap = s;
  endtask

  task automatic idle(input int n);
    cv <= 1'h0;
    sus <= 1'h0;
    gap = 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    chk(bus.dev_dq_oe === 1'b0 && busy === 1'b0, "reset drive");
    chk(bus.chip_select_low_a === PZT_SEL_A_OFF, "reset select");
    chk(rdy === 1'b1 && rdv === 1'b0, "reset ready");
    rst_n <= 1'h1;
    // Rows: background word, lane-strobed word, then read back
    foreach (ra[i])
    begin
      beat(1'h1, 1'h1, ra[i], 36'h0, 4'h0, 1'h0);
      beat(1'h1, 1'h1, ra[i], 36'h9abcdef12, rb[i], 1'h0);
      beat(1'h1, 1'h0, ra[i], 36'h0, 4'hf, 1'h0);
    end
    // Write bursts then read bursts, each load on the first beat;
    // advances carry the opposite direction, which must be ignored
    for (int b = 0; b < 4; b++)
    begin
      ord = b[0];
      for (int j = 0; j < 4; j++)
        beat(j == 0, (b < 2) == (j == 0), b[0] ? 17'h203 : 17'h101,
             36'h5a5a5a5a5 ^ 36'(b * 4 + j), 4'h0, b[0] & j[0]);
    end
    // Single reads, each followed by a gated cycle; they reach words of
    // both bursts, but a wrong burst order shows up here only for the linear burst at 101
    for (int j = 0; j < 4; j++)
      beat(1'h1, 1'h0, (j[0] ? 17'h200 : 17'h100) | 17'(j), 36'h0, 4'hf,
           1'h1);
    idle(12);
    chk(gotq.size() == expq.size(), "read word count");
    foreach (expq[i])
      chk(gotq[i] === expq[i], "read word");
    foreach (rx[i])
      chk(gotq[i] === rx[i], "row word");
    chk(busy === 1'b0, "busy after drain");
    close_out();
  end

  // Watchdog: about sixty times the expected run
  initial
  begin
    #80000;
    failures++;
    close_out();
  end
endmodule // pipelined_zero_turnaround_sram_port_bench
